/* hdl/tcc_pkg.sv */
package tcc_pkg;

  // Register map (8-bit data, byte-wide registers).
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
  localparam logic [3:0] ADDR_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_CAP1_HI = 4'h3;
  localparam logic [3:0] ADDR_CAP1_LO = 4'h4;
  localparam logic [3:0] ADDR_CMP1_HI = 4'h5;
  localparam logic [3:0] ADDR_CMP1_LO = 4'h6;
  localparam logic [3:0] ADDR_CNT_HI = 4'h7;
  localparam logic [3:0] ADDR_CNT_LO = 4'h8;
  localparam logic [3:0] ADDR_CAP2_HI = 4'h9;
  localparam logic [3:0] ADDR_CAP2_LO = 4'hA;
  localparam logic [3:0] ADDR_CMP2_HI = 4'hB;
  localparam logic [3:0] ADDR_CMP2_LO = 4'hC;

  // Control register one fields.
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_LEVEL2 = 5;
  localparam int C1_EDGE1 = 4;
  localparam int C1_LEVEL1 = 3;
  localparam int C1_FORCE2 = 2;
  localparam int C1_FORCE1 = 1;

  // Control register two fields.
  localparam int C2_PIN_EN1 = 7;
  localparam int C2_PIN_EN2 = 6;
  localparam int C2_SINGLE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_EDGE2 = 1;

  // Flags register fields.
  localparam int F_CAP1 = 7;
  localparam int F_CMP1 = 6;
  localparam int F_CAP2 = 5;
  localparam int F_CMP2 = 4;

  localparam logic [15:0] CNT_RESET = 16'hFFFC;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [1:0] CLK_EXTERNAL = 2'h3;

  typedef enum logic [1:0] {
    TCC_DIV2 = 2'b00,
    TCC_DIV4 = 2'b01,
    TCC_DIV8 = 2'b10,
    TCC_EXT = 2'b11
  } tcc_clksel_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcc_bus_t;

endpackage

/* hdl/tcc_top.sv */
`timescale 1ns/10ps
// Functional notes
// - Capture copies counter on selected pin edge.
// - Edge select bits in control one, two.
// - Capture sets flag; interrupt gated, stays pending.
// - One capture enable gates both channels.
// - Capture flag cleared: flags read, low access.
// - High byte read blocks capture until low.
// - Newest capture overwrites the previous value.
// - Pulse modes leave capture two working; single-pulse also keeps compare two flag.
// - Capture pins always feed capture logic.
// - Compare match sets flag, pin, interrupt.
// - Compare pin latch low during reset.
// - Compare registers software-only, reset 8000h.
// - Compare flag cleared: flags read, low access.
// - High byte write inhibits compare until low.
// - Disabled pin: no level, interrupt still possible.
// - Flag and pin asserted while counter equals.
// - Force bit copies level, no flag, no irq.
// - Force bits ignored in pulse modes.
// - Single-pulse select takes capture one, compare one.
// - Counter resets and reloads to FFFCh.
// - Timer clock divides by 2, 4, 8 or external.
module tcc_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire tcc_pkg::tcc_bus_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic cpu_mask_i,
  input wire logic ext_clk_i,
  input wire logic capture_pin_one_i,
  input wire logic capture_pin_two_i,
  output logic compare_pin_one_o,
  output logic compare_pin_two_o,
  output logic compare_pin_one_oe_o,
  output logic compare_pin_two_oe_o,
  output logic irq_o
);

  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [15:0] cnt_q;
  logic [2:0] pre_q;
  logic [2:0] ext_q;
  logic tick;
  logic [1:0] syn1_q;
  logic [1:0] syn2_q;
  logic [1:0] prev_q;
  logic [1:0] edge_hit;
  logic [15:0] cap_q [2];
  logic [1:0] cap_lock_q;
  logic [15:0] cmp_q [2];
  logic [1:0] cmp_inh_q;
  logic [1:0] cap_flag_q;
  logic [1:0] cmp_flag_q;
  logic [1:0] cap_armed_q;
  logic [1:0] cmp_armed_q;
  logic [1:0] match;
  logic [1:0] pin_q;
  logic pulse_mode;
  logic [1:0] cap_low_acc;
  logic [1:0] cmp_low_acc;
  logic flags_rd;
  logic [7:0] flags;
  logic [7:0] cnt_lo_buf_q;
  logic cnt_buf_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] t,
                               input logic s);
    hit = s && (a == t);
  endfunction

  assign pulse_mode = ctrl2_q[tcc_pkg::C2_SINGLE] | ctrl2_q[tcc_pkg::C2_PWM];
  assign flags_rd = hit(bus_i.addr, tcc_pkg::ADDR_FLAGS, bus_i.rd);
  assign cap_low_acc[0] = hit(bus_i.addr, tcc_pkg::ADDR_CAP1_LO,
                              bus_i.rd | bus_i.wr);
  assign cap_low_acc[1] = hit(bus_i.addr, tcc_pkg::ADDR_CAP2_LO,
                              bus_i.rd | bus_i.wr);
  assign cmp_low_acc[0] = hit(bus_i.addr, tcc_pkg::ADDR_CMP1_LO,
                              bus_i.rd | bus_i.wr);
  assign cmp_low_acc[1] = hit(bus_i.addr, tcc_pkg::ADDR_CMP2_LO,
                              bus_i.rd | bus_i.wr);
  assign flags = {cap_flag_q[0], cmp_flag_q[0], cap_flag_q[1],
                  cmp_flag_q[1], 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl1_q <= 8'h00;
      ctrl2_q <= 8'h00;
    end
    else
    begin
      // Force bits act once, even under back-to-back writes elsewhere.
      if (bus_i.wr && bus_i.addr == tcc_pkg::ADDR_CTRL_ONE)
        ctrl1_q <= bus_i.wdata;
      else
      begin
        ctrl1_q[tcc_pkg::C1_FORCE1] <= 1'b0;
        ctrl1_q[tcc_pkg::C1_FORCE2] <= 1'b0;
      end
      if (bus_i.wr && bus_i.addr == tcc_pkg::ADDR_CTRL_TWO)
        ctrl2_q <= bus_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and free-running counter.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pre_q <= 3'h0;
      ext_q <= 3'h0;
    end
    else
    begin
      pre_q <= pre_q + 3'h1;
      ext_q <= {ext_q[1:0], ext_clk_i};
    end
  end

  always_comb
  begin
    case (tcc_pkg::tcc_clksel_t'(ctrl2_q[tcc_pkg::C2_CLK_HI:
                                         tcc_pkg::C2_CLK_LO]))
      tcc_pkg::TCC_DIV2: tick = pre_q[0];
      tcc_pkg::TCC_DIV4: tick = &pre_q[1:0];
      tcc_pkg::TCC_DIV8: tick = &pre_q;
      tcc_pkg::TCC_EXT: tick = ext_q[1] & ~ext_q[2];
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cnt_q <= tcc_pkg::CNT_RESET;
    else if (bus_i.wr && bus_i.addr == tcc_pkg::ADDR_CNT_LO)
      cnt_q <= tcc_pkg::CNT_RESET;
    else if (tick)
      cnt_q <= cnt_q + 16'h0001;
  end

  // Counter low byte is buffered on a high-byte read for a coherent pair.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_buf_q <= 1'b0;
      cnt_lo_buf_q <= 8'h00;
    end
    else if (hit(bus_i.addr, tcc_pkg::ADDR_CNT_HI, bus_i.rd) && !cnt_buf_q)
    begin
      cnt_buf_q <= 1'b1;
      cnt_lo_buf_q <= cnt_q[7:0];
    end
    else if (hit(bus_i.addr, tcc_pkg::ADDR_CNT_LO, bus_i.rd))
      cnt_buf_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input capture.

  // No reset: the chain follows the pins through reset, so a pin that
  // idles high gives no false edge when reset is released.
  always_ff @(posedge clk_i)
  begin
    // The pins feed this path whatever their direction.
    syn1_q <= {capture_pin_two_i, capture_pin_one_i};
    syn2_q <= syn1_q;
    prev_q <= syn2_q;
  end

  // Edges are taken on the system clock so none is missed between ticks.
  assign edge_hit[0] = ctrl1_q[tcc_pkg::C1_EDGE1] ? (syn2_q[0] & ~prev_q[0])
                       : (~syn2_q[0] & prev_q[0]);
  assign edge_hit[1] = ctrl2_q[tcc_pkg::C2_EDGE2] ? (syn2_q[1] & ~prev_q[1])
                       : (~syn2_q[1] & prev_q[1]);

  logic [1:0] cap_ev;
  assign cap_ev[0] = edge_hit[0] & ~cap_lock_q[0] & ~pulse_mode;
  assign cap_ev[1] = edge_hit[1] & ~cap_lock_q[1];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cap_q[0] <= 16'h0000;
      cap_q[1] <= 16'h0000;
      cap_lock_q <= 2'b00;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (cap_ev[i])
          cap_q[i] <= cnt_q;
      end
      if (hit(bus_i.addr, tcc_pkg::ADDR_CAP1_HI, bus_i.rd))
        cap_lock_q[0] <= 1'b1;
      else if (hit(bus_i.addr, tcc_pkg::ADDR_CAP1_LO, bus_i.rd))
        cap_lock_q[0] <= 1'b0;
      if (hit(bus_i.addr, tcc_pkg::ADDR_CAP2_HI, bus_i.rd))
        cap_lock_q[1] <= 1'b1;
      else if (hit(bus_i.addr, tcc_pkg::ADDR_CAP2_LO, bus_i.rd))
        cap_lock_q[1] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output compare.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cmp_q[0] <= tcc_pkg::CMP_RESET;
      cmp_q[1] <= tcc_pkg::CMP_RESET;
      cmp_inh_q <= 2'b00;
    end
    else if (bus_i.wr)
    begin
      case (bus_i.addr)
        tcc_pkg::ADDR_CMP1_HI:
        begin
          cmp_q[0][15:8] <= bus_i.wdata;
          cmp_inh_q[0] <= 1'b1;
        end
        tcc_pkg::ADDR_CMP1_LO:
        begin
          cmp_q[0][7:0] <= bus_i.wdata;
          cmp_inh_q[0] <= 1'b0;
        end
        tcc_pkg::ADDR_CMP2_HI:
        begin
          cmp_q[1][15:8] <= bus_i.wdata;
          cmp_inh_q[1] <= 1'b1;
        end
        tcc_pkg::ADDR_CMP2_LO:
        begin
          cmp_q[1][7:0] <= bus_i.wdata;
          cmp_inh_q[1] <= 1'b0;
        end
        default: cmp_inh_q <= cmp_inh_q;
      endcase
    end
  end

  // Match holds for every system cycle the counter equals the value.
  assign match[0] = (cnt_q == cmp_q[0]) & ~cmp_inh_q[0];
  assign match[1] = (cnt_q == cmp_q[1]) & ~cmp_inh_q[1];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pin_q <= 2'b00;
    else
    begin
      if (!pulse_mode && ctrl1_q[tcc_pkg::C1_FORCE1])
        pin_q[0] <= ctrl1_q[tcc_pkg::C1_LEVEL1];
      else if (match[0] && !pulse_mode)
        pin_q[0] <= ctrl1_q[tcc_pkg::C1_LEVEL1];
      if (!pulse_mode && ctrl1_q[tcc_pkg::C1_FORCE2])
        pin_q[1] <= ctrl1_q[tcc_pkg::C1_LEVEL2];
      else if (match[1] && !pulse_mode)
        pin_q[1] <= ctrl1_q[tcc_pkg::C1_LEVEL2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      compare_pin_one_o <= 1'b0;
      compare_pin_two_o <= 1'b0;
      compare_pin_one_oe_o <= 1'b0;
      compare_pin_two_oe_o <= 1'b0;
    end
    else
    begin
      compare_pin_one_o <= pin_q[0];
      compare_pin_two_o <= pin_q[1];
      compare_pin_one_oe_o <= ctrl2_q[tcc_pkg::C2_PIN_EN1];
      compare_pin_two_oe_o <= ctrl2_q[tcc_pkg::C2_PIN_EN2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a set in the clearing cycle wins.

  logic [1:0] cmp_set;
  assign cmp_set[0] = match[0] & ~ctrl2_q[tcc_pkg::C2_SINGLE]
                      & ~ctrl2_q[tcc_pkg::C2_PWM];
  assign cmp_set[1] = match[1] & ~ctrl2_q[tcc_pkg::C2_PWM];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cap_flag_q <= 2'b00;
      cmp_flag_q <= 2'b00;
      cap_armed_q <= 2'b00;
      cmp_armed_q <= 2'b00;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (cap_ev[i])
          cap_flag_q[i] <= 1'b1;
        else if (cap_armed_q[i] && cap_low_acc[i])
          cap_flag_q[i] <= 1'b0;
        if (cmp_set[i])
          cmp_flag_q[i] <= 1'b1;
        else if (cmp_armed_q[i] && cmp_low_acc[i])
          cmp_flag_q[i] <= 1'b0;
        if (flags_rd && cap_flag_q[i])
          cap_armed_q[i] <= 1'b1;
        else if (cap_low_acc[i])
          cap_armed_q[i] <= 1'b0;
        if (flags_rd && cmp_flag_q[i])
          cmp_armed_q[i] <= 1'b1;
        else if (cmp_low_acc[i])
          cmp_armed_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= !cpu_mask_i &&
               ((ctrl1_q[tcc_pkg::C1_CAP_IE] && |cap_flag_q) ||
                (ctrl1_q[tcc_pkg::C1_CMP_IE] && |cmp_flag_q));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe; unmapped reads return zero.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rdata_o <= 8'h00;
    else if (bus_i.rd)
    begin
      case (bus_i.addr)
        tcc_pkg::ADDR_CTRL_ONE: rdata_o <= ctrl1_q;
        tcc_pkg::ADDR_CTRL_TWO: rdata_o <= ctrl2_q;
        tcc_pkg::ADDR_FLAGS: rdata_o <= flags;
        tcc_pkg::ADDR_CAP1_HI: rdata_o <= cap_q[0][15:8];
        tcc_pkg::ADDR_CAP1_LO: rdata_o <= cap_q[0][7:0];
        tcc_pkg::ADDR_CAP2_HI: rdata_o <= cap_q[1][15:8];
        tcc_pkg::ADDR_CAP2_LO: rdata_o <= cap_q[1][7:0];
        tcc_pkg::ADDR_CMP1_HI: rdata_o <= cmp_q[0][15:8];
        tcc_pkg::ADDR_CMP1_LO: rdata_o <= cmp_q[0][7:0];
        tcc_pkg::ADDR_CMP2_HI: rdata_o <= cmp_q[1][15:8];
        tcc_pkg::ADDR_CMP2_LO: rdata_o <= cmp_q[1][7:0];
        tcc_pkg::ADDR_CNT_HI: rdata_o <= cnt_q[15:8];
        tcc_pkg::ADDR_CNT_LO: rdata_o <= cnt_buf_q ? cnt_lo_buf_q : cnt_q[7:0];
        default: rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_CAP_LOAD: assert property (@(posedge clk_i)
    disable iff (reset_i) cap_ev[1] |=> cap_q[1] == $past(cnt_q))
    else $error("capture two did not load counter");
  AST_CAP_LOCK: assert property (@(posedge clk_i)
    disable iff (reset_i) cap_lock_q[1] |=> $stable(cap_q[1]))
    else $error("capture while locked");
  AST_CAP1_PULSE: assert property (@(posedge clk_i)
    disable iff (reset_i) pulse_mode && edge_hit[0] |=> $stable(cap_q[0]))
    else $error("capture one active in pulse mode");
  AST_CAP_FLAG: assert property (@(posedge clk_i)
    disable iff (reset_i) cap_ev[0] |=> cap_flag_q[0])
    else $error("capture flag not set");
  AST_CAP_CLR: assert property (@(posedge clk_i)
    disable iff (reset_i)
    !cap_armed_q[0] && !cap_ev[0] && cap_flag_q[0] |=> cap_flag_q[0])
    else $error("capture flag cleared without flags read");
  AST_CMP_INH: assert property (@(posedge clk_i)
    disable iff (reset_i)
    bus_i.wr && bus_i.addr == tcc_pkg::ADDR_CMP1_HI |=> !match[0])
    else $error("compare not inhibited");
  AST_CMP_FLAG: assert property (@(posedge clk_i)
    disable iff (reset_i) match[1] && !pulse_mode |=> cmp_flag_q[1])
    else $error("compare flag not set");
  AST_IRQ: assert property (@(posedge clk_i)
    disable iff (reset_i) cpu_mask_i |=> !irq_o)
    else $error("interrupt while masked");
  AST_CNT_LOAD: assert property (@(posedge clk_i)
    disable iff (reset_i)
    bus_i.wr && bus_i.addr == tcc_pkg::ADDR_CNT_LO |=>
    cnt_q == tcc_pkg::CNT_RESET)
    else $error("counter not reloaded");
  AST_PIN_RESET: assert property (@(posedge clk_i)
    reset_i |=> !compare_pin_one_o && !compare_pin_two_o)
    else $error("compare pin not low after reset");

endmodule

/* tb/tcc_pin_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Board side of the timer pins: two capture sources and two compare lines.
// The compare lines carry a pull-up, so an undriven pin reads high here.
module tcc_pin_model (
  input wire logic clk_i,
  input wire logic compare_pin_one_i,
  input wire logic compare_pin_two_i,
  input wire logic compare_pin_one_oe_i,
  input wire logic compare_pin_two_oe_i,
  output logic capture_pin_one_o,
  output logic capture_pin_two_o,
  output logic line_one_o,
  output logic line_two_o
);
  initial
  begin
    capture_pin_one_o = 1'b0;
    capture_pin_two_o = 1'b0;
  end

  assign line_one_o = compare_pin_one_oe_i ? compare_pin_one_i : 1'b1;
  assign line_two_o = compare_pin_two_oe_i ? compare_pin_two_i : 1'b1;

  // Each level is held for several clocks so the input synchroniser
  // cannot miss it.
  task automatic drive(input int ch, input logic v);
    @(posedge clk_i);
    if (ch == 1)
      capture_pin_one_o <= v;
    else
      capture_pin_two_o <= v;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cpu_mask = 1'b0;
  logic ext_clk = 1'b0;
  tcc_pkg::tcc_bus_t bus = '0;
  logic [7:0] rdata, b;
  logic cap_one, cap_two, cmp_one, cmp_two, oe_one, oe_two, irq;
  logic line_one, line_two;
  logic [15:0] v, w;
  int miscompares = 0;
  int check_count = 0;

  always #5 clk_i = ~clk_i;

  tcc_top u_tcc_top (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus),
    .rdata_o(rdata), .cpu_mask_i(cpu_mask), .ext_clk_i(ext_clk),
    .capture_pin_one_i(cap_one), .capture_pin_two_i(cap_two),
    .compare_pin_one_o(cmp_one), .compare_pin_two_o(cmp_two),
    .compare_pin_one_oe_o(oe_one), .compare_pin_two_oe_o(oe_two),
    .irq_o(irq));

  tcc_pin_model u_tcc_pin_model (.clk_i(clk_i),
    .compare_pin_one_i(cmp_one), .compare_pin_two_i(cmp_two),
    .compare_pin_one_oe_i(oe_one), .compare_pin_two_oe_i(oe_two),
    .capture_pin_one_o(cap_one), .capture_pin_two_o(cap_two),
    .line_one_o(line_one), .line_two_o(line_two));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("reg_%h", a), {8'h00, e}, {8'h00, d});
  endtask

  // High byte first: it locks or buffers the low byte.
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    logic [7:0] h, l;
    rd(a, h);
    rd(a + 4'h1, l);
    d = {h, l};
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400)
    begin
      miscompares++;
      $display("CHECK FAILED irq expected 1 seen %b", irq);
    end
  endtask

  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_i);
    #1;
    chk("pin_one_in_reset", 16'h0000, {15'h0, cmp_one});
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rdc(tcc_pkg::ADDR_CMP1_HI, 8'h80);
    rdc(tcc_pkg::ADDR_CMP1_LO, 8'h00);
    rdc(tcc_pkg::ADDR_CMP2_HI, 8'h80);
    rdc(tcc_pkg::ADDR_CMP2_LO, 8'h00);
    rdc(tcc_pkg::ADDR_FLAGS, 8'h00);
    rdc(4'hD, 8'h00);
    // Compare: channel one enabled, channel two left half written.
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h48);
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'h80);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    wr(tcc_pkg::ADDR_CMP1_HI, 8'h00);
    wr(tcc_pkg::ADDR_CMP1_LO, 8'h10);
    wr(tcc_pkg::ADDR_CMP2_HI, 8'h00);
    wait_irq();
    repeat (4) @(posedge clk_i);
    chk("pin_one", 16'h0001, {15'h0, cmp_one});
    chk("pin_one_oe", 16'h0001, {15'h0, oe_one});
    chk("line_two", 16'h0001, {15'h0, line_two});
    rdc(tcc_pkg::ADDR_FLAGS, 8'h40);
    @(posedge clk_i);
    cpu_mask <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("irq_masked", 16'h0000, {15'h0, irq});
    @(posedge clk_i);
    cpu_mask <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("irq_pending", 16'h0001, {15'h0, irq});
    wr(tcc_pkg::ADDR_CMP1_LO, 8'h10);
    rdc(tcc_pkg::ADDR_FLAGS, 8'h00);
    wr(tcc_pkg::ADDR_CMP2_LO, 8'h60);
    wait_irq();
    chk("pin_two_oe", 16'h0000, {15'h0, oe_two});
    chk("line_two_idle", 16'h0001, {15'h0, line_two});
    rdc(tcc_pkg::ADDR_CMP2_LO, 8'h60);
    rdc(tcc_pkg::ADDR_FLAGS, 8'h10);
    rdc(tcc_pkg::ADDR_CMP2_LO, 8'h60);
    rdc(tcc_pkg::ADDR_FLAGS, 8'h00);
    // Forced output levels.
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h42);
    repeat (3) @(posedge clk_i);
    chk("force_low", 16'h0000, {15'h0, cmp_one});
    chk("line_one_low", 16'h0000, {15'h0, line_one});
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h6E);
    repeat (3) @(posedge clk_i);
    chk("force_high", 16'h0001, {15'h0, cmp_one});
    chk("force_two", 16'h0001, {15'h0, cmp_two});
    chk("force_irq", 16'h0000, {15'h0, irq});
    rdc(tcc_pkg::ADDR_FLAGS, 8'h00);
    // Capture: channel one on rising, channel two on falling edges.
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h90);
    rd16(tcc_pkg::ADDR_CNT_HI, w);
    u_tcc_pin_model.drive(1, 1'b1);
    wait_irq();
    rdc(tcc_pkg::ADDR_FLAGS, 8'h80);
    rd16(tcc_pkg::ADDR_CAP1_HI, v);
    chk("cap1_window", 16'h0001, {15'h0, (v - w) <= 16'h0010});
    rdc(tcc_pkg::ADDR_FLAGS, 8'h00);
    u_tcc_pin_model.drive(1, 1'b0);
    u_tcc_pin_model.drive(2, 1'b1);
    repeat (6) @(posedge clk_i);
    rdc(tcc_pkg::ADDR_FLAGS, 8'h00);
    u_tcc_pin_model.drive(2, 1'b0);
    wait_irq();
    rdc(tcc_pkg::ADDR_FLAGS, 8'h20);
    rd(tcc_pkg::ADDR_CAP2_HI, b);
    u_tcc_pin_model.drive(2, 1'b1);
    u_tcc_pin_model.drive(2, 1'b0);
    repeat (6) @(posedge clk_i);
    rd(tcc_pkg::ADDR_CAP2_LO, v[7:0]);
    v[15:8] = b;
    rdc(tcc_pkg::ADDR_FLAGS, 8'h00);
    rd16(tcc_pkg::ADDR_CAP2_HI, w);
    chk("cap2_locked", v, w);
    u_tcc_pin_model.drive(2, 1'b1);
    u_tcc_pin_model.drive(2, 1'b0);
    wait_irq();
    rd16(tcc_pkg::ADDR_CAP2_HI, w);
    chk("cap2_newer", 16'h0001, {15'h0, w > v});
    // Single-pulse mode takes capture one and the forced levels.
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'hA0);
    rd16(tcc_pkg::ADDR_CAP1_HI, v);
    u_tcc_pin_model.drive(1, 1'b1);
    repeat (6) @(posedge clk_i);
    rd16(tcc_pkg::ADDR_CAP1_HI, w);
    chk("cap1_single", v, w);
    wr(tcc_pkg::ADDR_CTRL_ONE, 8'h02);
    repeat (3) @(posedge clk_i);
    chk("force_single", 16'h0001, {15'h0, cmp_one});
    // Prescaler taps: 81 counting edges between reload and high-byte read.
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'h04);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    repeat (80) @(posedge clk_i);
    rd16(tcc_pkg::ADDR_CNT_HI, w);
    chk("div4", 16'h0001, {15'h0, w == 16'h0010 || w == 16'h0011});
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'h08);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    repeat (80) @(posedge clk_i);
    rd16(tcc_pkg::ADDR_CNT_HI, w);
    chk("div8", 16'h0001, {15'h0, w == 16'h0006 || w == 16'h0007});
    // External clock: five slow rising edges, one count each.
    wr(tcc_pkg::ADDR_CTRL_TWO, 8'h0C);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    repeat (5)
    begin
      @(posedge clk_i);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    rd16(tcc_pkg::ADDR_CNT_HI, w);
    chk("ext_count", 16'h0001, w);
    tally_and_finish();
  end
endmodule
